// ### src/hpa_defs.vh
// Constants for the housekeeping packet assembler
`ifndef HPA_DEFS_VH
`define HPA_DEFS_VH

// ============================================================
// Clock plan
// ============================================================
`define HPA_MASTER_HZ      4194304      // Master clock input, 2^22 Hz
`define HPA_CORE_HZ        262144       // Core clock output
`define HPA_CONV_HZ        65536        // Convolutional encoder clock output
`define HPA_FRAME_HZ       32768        // Frame clock and serial bit rate
`define HPA_DIV_W          7            // Divider width, master / 128 at the top
`define HPA_CORE_BIT       3            // Divider bit giving master / 16
`define HPA_CONV_BIT       5            // Divider bit giving master / 64
`define HPA_FRAME_BIT      6            // Divider bit giving master / 128
`define HPA_FINE_HZ        4            // Fine time tick rate, quarter seconds
`define HPA_QSEC_TICKS     (`HPA_MASTER_HZ / `HPA_FINE_HZ)   // Master edges per fine tick
`define HPA_MARKER_MS      125          // Acquisition marker width
`define HPA_MARKER_TICKS   (`HPA_MASTER_HZ * `HPA_MARKER_MS / 1000)

// ============================================================
// Mission time counter
// ============================================================
`define HPA_MET_W          26           // 24 coarse + 2 fine bits
`define HPA_MET_RESET      26'h0000000
`define HPA_SLOT_MASK      4'hf         // Fine 2 bits + coarse 2 bits = 4 s slot

// ============================================================
// Packet layout (packet octet index, header included)
// ============================================================
`define HPA_PKT_OCTETS     7'h45        // 69 octets
`define HPA_PKT_LAST       7'h44
`define HPA_HDR0           8'h87        // Version 100, type 0, flag 0, id bits 10..8
`define HPA_HDR1           8'h77        // Id bits 7..0
`define HPA_SEG_FLAGS      2'h3         // Segmentation flags 11
`define HPA_LEN_HI         8'h00        // Length field 003e
`define HPA_LEN_LO         8'h3e
`define HPA_SYNC0          8'heb
`define HPA_SYNC1          8'h90
`define HPA_SYNC2          8'hc0
`define HPA_SYNC3          8'h24
`define HPA_OCT_TIME       7'h0a        // Coarse time, three octets
`define HPA_OCT_DISC       7'h0d        // Discrete channels, two octets
`define HPA_OCT_AUX        7'h0f        // First octet from the sub-modules

`endif

// ### src/hpa_fifo.v
// Octet FIFO between the packet producer and the serialiser
`timescale 1ns/1ps
`default_nettype none

module hpa_fifo #(
    parameter WIDTH = 8,                 // Word width
    parameter DEPTH = 16,                // Number of words
    parameter AW    = 4                  // Pointer width, log2 of depth
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    // ============================================================
    // Storage and pointers
    // ============================================================
    reg  [WIDTH-1:0] mem_r [0:DEPTH-1];  // Word store
    reg  [AW-1:0]    wp_r;               // Write pointer
    reg  [AW-1:0]    rp_r;               // Read pointer
    reg  [AW:0]      cnt_r;              // Fill level, one bit wider than pointers
    wire             push;               // Word accepted
    wire             pop;                // Word taken

    localparam [AW:0] FULL = DEPTH[AW:0]; // Fill level that refuses writes

    assign in_ready  = (cnt_r != FULL);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_r[rp_r];

    // Store is not reset; only the pointers and fill level say what is valid
    always @(posedge clk)
    begin
        if (push)
            mem_r[wp_r] <= in_data;
    end

    // Pointers and level; simultaneous push and pop keep the level
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
            if (pop)
                rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
            if (push & ~pop)
                cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
            else if (pop & ~push)
                cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
        end
    end

endmodule // hpa_fifo

`default_nettype wire

// ### src/hpa_top.v
// Housekeeping packet assembler: clocks, mission time, packet build and serial output
//
// Notes on behaviour
// - Divide master clock to 65536 Hz output
// - Divide master clock to 32768 Hz output
// - Output 262144 Hz core clock, board loops back
// - Reset released through two flip-flops
// - Every packet exactly 69 octets long
// - Header, sync, time, discretes, status, in order
// - Sixteen blocks: analogue octet, two sun octets
// - Packet every 4 s, sun sampling 4 Hz
// - Sampling on integer-second time values
// - Sink not ready at slot: skip packet
// - Header version, type, flag, id, segmentation fixed
// - Sequence count is coarse time bits 15..2
// - Length field constant 003e
// - Data octets 0..3 are eb 90 c0 24
// - Mission time 24 coarse, 2 fine bits
// - Coarse time in octets 4..6, MSB first
// - Fine time drives acquisition and sun strobes
// - 125 ms marker pulse when acquisition begins
// - Discretes registered, index 0 first bit
// - Serial clock, valid and data outputs
// - Serial bits at 32768 bit/s
`timescale 1ns/1ps
`default_nettype none
`include "hpa_defs.vh"

module hpa_top #(
    parameter QSEC_TICKS = `HPA_QSEC_TICKS,   // Master edges per quarter second
    parameter MARK_TICKS = `HPA_MARKER_TICKS, // Master edges the marker stays high
    parameter FIFO_DEPTH = 16,                // Octet FIFO depth
    parameter FIFO_AW    = 4                  // Octet FIFO pointer width
) (
    input  wire        clk,
    input  wire        rstn,
    input  wire        master_clock_in,
    output wire        conv_encoder_clock_out,
    output wire        frame_clock_out,
    output wire        core_clock_out,
    input  wire        sink_room_ready,
    input  wire [15:0] discrete_inputs,
    output wire [6:0]  aux_octet_index,
    input  wire [7:0]  aux_octet_data,
    output wire        acq_start_strobe,
    output wire        sun_sample_strobe,
    output wire        acquisition_marker,
    output wire [25:0] mission_time_counter,
    output wire        tm_serial_clock,
    output wire        tm_serial_valid,
    output wire        tm_serial_data
);

    // ============================================================
    // Local constants and helpers
    // ============================================================
    localparam [19:0] QLAST = QSEC_TICKS[19:0] - 20'h00001; // Last master edge of a fine tick
    localparam [19:0] MLAST = MARK_TICKS[19:0] - 20'h00001; // Last master edge of the marker
    localparam [1:0]  ST_IDLE = 2'b01;          // Producer waits for a slot
    localparam [1:0]  ST_PUSH = 2'b10;          // Producer feeds the FIFO

    // Index 0 of a discrete group goes to the first transmitted bit
    function [7:0] rev8;
        input [7:0] v;
        integer i;
        begin
            for (i = 0; i < 8; i = i + 1)
                rev8[7-i] = v[i];
        end
    endfunction

    // ============================================================
    // Reset synchroniser
    // ============================================================
    reg rs1_r;                                   // First reset stage
    reg rs2_r;                                   // Second stage, core reset
    wire rst_n = rs2_r;                          // Released reset for all core logic

    // Assert at once, release two edges later so no flop sees a late release
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rs1_r <= 1'b0;
            rs2_r <= 1'b0;
        end
        else
        begin
            rs1_r <= 1'b1;
            rs2_r <= rs1_r;
        end
    end

    // ============================================================
    // Pin synchronisers
    // ============================================================
    reg        mc1_r, mc2_r, mc3_r;              // Master clock stages, third for edge
    reg        rdy1_r, rdy2_r;                   // Sink ready stages
    reg [15:0] di1_r, di2_r;                     // Discrete input stages
    wire       master_rise = mc2_r & ~mc3_r;     // One clk per master rising edge

    // Two stages for every pin; logic reads the second stage, and the master edge detect also reads the third
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mc1_r  <= 1'b0;
            mc2_r  <= 1'b0;
            mc3_r  <= 1'b0;
            rdy1_r <= 1'b0;
            rdy2_r <= 1'b0;
            di1_r  <= 16'h0000;
            di2_r  <= 16'h0000;
        end
        else
        begin
            mc1_r  <= master_clock_in;
            mc2_r  <= mc1_r;
            mc3_r  <= mc2_r;
            rdy1_r <= sink_room_ready;
            rdy2_r <= rdy1_r;
            di1_r  <= discrete_inputs;
            di2_r  <= di1_r;
        end
    end

    // ============================================================
    // Clock dividers and fine-time divider
    // ============================================================
    reg  [`HPA_DIV_W-1:0] div_r;                 // Master edge counter for clock outputs
    reg  [19:0]           qcnt_r;                // Master edges inside a quarter second
    wire                  qtick;                 // One clk at each quarter second
    wire                  bit_tick;              // Frame clock falling edge

    assign qtick    = master_rise & (qcnt_r == QLAST);
    assign bit_tick = master_rise & (&div_r);
    assign core_clock_out         = div_r[`HPA_CORE_BIT];
    assign conv_encoder_clock_out = div_r[`HPA_CONV_BIT];
    assign frame_clock_out        = div_r[`HPA_FRAME_BIT];
    assign tm_serial_clock        = div_r[`HPA_FRAME_BIT];

    // Outputs are divider flops, so they are glitch free at a fixed ratio
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_r  <= {`HPA_DIV_W{1'b0}};
            qcnt_r <= 20'h00000;
        end
        else if (master_rise)
        begin
            div_r <= div_r + {{(`HPA_DIV_W-1){1'b0}}, 1'b1};
            if (qcnt_r == QLAST)
                qcnt_r <= 20'h00000;
            else
                qcnt_r <= qcnt_r + 20'h00001;
        end
    end

    // ============================================================
    // Mission time counter and acquisition timing
    // ============================================================
    reg  [`HPA_MET_W-1:0] met_r;                 // Coarse 25..2, fine 1..0
    wire [`HPA_MET_W-1:0] met_nxt = met_r + 26'h0000001;
    wire                  slot;                  // 4 s boundary on a whole second
    reg                   acq_r;                 // Acquisition period running
    reg                   mark_r;                // Marker output
    reg  [19:0]           mcnt_r;                // Marker length counter
    reg  [13:0]           acq_ssc_r;             // Sequence count taken at start
    reg  [23:0]           acq_time_r;            // Coarse time taken at start
    reg  [15:0]           acq_disc_r;            // Discretes taken at start
    reg  [13:0]           em_ssc_r;              // Copies used while emitting
    reg  [23:0]           em_time_r;
    reg  [15:0]           em_disc_r;
    reg  [1:0]            st_r;                  // Producer state
    wire                  start_acq;             // New acquisition begins
    wire                  emit;                  // Finished acquisition goes out

    // Slot when fine bits and coarse bits 1..0 all roll to zero
    assign slot      = qtick & ((met_nxt[3:0] & `HPA_SLOT_MASK) == 4'h0);
    assign start_acq = slot & rdy2_r;
    assign emit      = start_acq & acq_r & (st_r == ST_IDLE);
    assign acq_start_strobe     = start_acq;
    assign sun_sample_strobe    = qtick & acq_r;
    assign acquisition_marker   = mark_r;
    assign mission_time_counter = met_r;

    // Time runs from reset; a slot with the sink full drops both the
    // finished packet and the next acquisition, which waits for the next slot
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            met_r      <= `HPA_MET_RESET;
            acq_r      <= 1'b0;
            mark_r     <= 1'b0;
            mcnt_r     <= 20'h00000;
            acq_ssc_r  <= 14'h0000;
            acq_time_r <= 24'h000000;
            acq_disc_r <= 16'h0000;
            em_ssc_r   <= 14'h0000;
            em_time_r  <= 24'h000000;
            em_disc_r  <= 16'h0000;
        end
        else
        begin
            if (qtick)
                met_r <= met_nxt;
            if (slot)
                acq_r <= rdy2_r;
            if (emit)
            begin
                em_ssc_r  <= acq_ssc_r;
                em_time_r <= acq_time_r;
                em_disc_r <= acq_disc_r;
            end
            if (start_acq)
            begin
                acq_ssc_r  <= met_nxt[17:4];
                acq_time_r <= met_nxt[25:2];
                acq_disc_r <= di2_r;
            end
            // Marker counts master edges so its width tracks the crystal
            if (start_acq)
            begin
                mark_r <= 1'b1;
                mcnt_r <= 20'h00000;
            end
            else if (mark_r & master_rise)
            begin
                if (mcnt_r == MLAST)
                    mark_r <= 1'b0;
                mcnt_r <= mcnt_r + 20'h00001;
            end
        end
    end

    // ============================================================
    // Packet producer
    // ============================================================
    reg  [6:0] idx_r;                            // Packet octet index
    reg  [7:0] oct;                              // Octet at the current index
    wire       f_ready;                          // FIFO has room
    wire       f_push = (st_r == ST_PUSH);       // Offer an octet

    assign aux_octet_index = idx_r;

    // Octet by packet index; sub-modules answer from index 15 on
    always @*
    begin
        case (idx_r)
            7'h00:   oct = `HPA_HDR0;
            7'h01:   oct = `HPA_HDR1;
            7'h02:   oct = {`HPA_SEG_FLAGS, em_ssc_r[13:8]};
            7'h03:   oct = em_ssc_r[7:0];
            7'h04:   oct = `HPA_LEN_HI;
            7'h05:   oct = `HPA_LEN_LO;
            7'h06:   oct = `HPA_SYNC0;
            7'h07:   oct = `HPA_SYNC1;
            7'h08:   oct = `HPA_SYNC2;
            7'h09:   oct = `HPA_SYNC3;
            7'h0a:   oct = em_time_r[23:16];
            7'h0b:   oct = em_time_r[15:8];
            7'h0c:   oct = em_time_r[7:0];
            7'h0d:   oct = rev8(em_disc_r[7:0]);
            7'h0e:   oct = rev8(em_disc_r[15:8]);
            default: oct = aux_octet_data;
        endcase
    end

    // Walks indices 0..68 once per emitted packet, stalled by the FIFO
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r  <= ST_IDLE;
            idx_r <= 7'h00;
        end
        else
        begin
            case (st_r)
                ST_IDLE:
                begin
                    idx_r <= 7'h00;
                    if (emit)
                        st_r <= ST_PUSH;
                end
                ST_PUSH:
                begin
                    if (f_ready)
                    begin
                        idx_r <= idx_r + 7'h01;
                        if (idx_r == `HPA_PKT_LAST)
                            st_r <= ST_IDLE;
                    end
                end
                default:
                    st_r <= ST_IDLE;
            endcase
        end
    end

    // ============================================================
    // Octet FIFO
    // ============================================================
    wire       s_valid;                          // Octet waiting for the serialiser
    wire       s_ready;                          // Serialiser takes an octet
    wire [7:0] s_data;

    hpa_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (f_push),
        .in_ready  (f_ready),
        .in_data   (oct),
        .out_valid (s_valid),
        .out_ready (s_ready),
        .out_data  (s_data)
    );

    // ============================================================
    // Serialiser
    // ============================================================
    reg  [7:0] sh_r;                             // Shift register, MSB goes out
    reg  [2:0] bcnt_r;                           // Bits already sent of this octet
    reg        busy_r;                           // A bit is on the line

    // Loads only at a frame clock fall so data is stable at the rising edge
    assign s_ready         = bit_tick & (~busy_r | (bcnt_r == 3'h7));
    assign tm_serial_data  = sh_r[7];
    assign tm_serial_valid = busy_r;

    // One bit per frame clock period; valid drops when no octet is ready
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sh_r   <= 8'h00;
            bcnt_r <= 3'h0;
            busy_r <= 1'b0;
        end
        else if (bit_tick)
        begin
            if (busy_r & (bcnt_r != 3'h7))
            begin
                sh_r   <= {sh_r[6:0], 1'b0};
                bcnt_r <= bcnt_r + 3'h1;
            end
            else if (s_valid)
            begin
                sh_r   <= s_data;
                bcnt_r <= 3'h0;
                busy_r <= 1'b1;
            end
            else
            begin
                sh_r   <= 8'h00;
                busy_r <= 1'b0;
            end
        end
    end

endmodule // hpa_top

`default_nettype wire

// ### dv/hpa_sink_model.sv
// Channel assembler serial input model with a commanded room flag
`timescale 1ns/1ps
`default_nettype none

module hpa_sink_model (
    input  wire logic room_en,
    output wire logic sink_room_ready,
    input  wire logic tm_serial_clock,
    input  wire logic tm_serial_valid,
    input  wire logic tm_serial_data
);
    // ========
    // Receiver
    logic [7:0] shift_r;     // Octet being gathered
    int         nbits = 0;   // Bits gathered so far
    logic [7:0] octets[$];   // Octets in arrival order

    // Room follows the bench; a stalled assembler simply drops it
    assign sink_room_ready = room_en;

    // Sample mid-bit on the rising serial clock, MSB arrives first
    always @(posedge tm_serial_clock)
    begin
        if (tm_serial_valid === 1'b1)
        begin
            shift_r = {shift_r[6:0], tm_serial_data};
            nbits   = nbits + 1;
            if (nbits % 8 == 0)
                octets.push_back(shift_r);
        end
    end
endmodule // hpa_sink_model

`default_nettype wire

// ### dv/hpa_checker.sv
// Port assertions for the housekeeping packet assembler
`timescale 1ns/1ps
`default_nettype none

module hpa_checker #(
    parameter int MARK_TICKS = 32   // Master edges the marker stays high
) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        master_clock_in,
    input wire logic        conv_encoder_clock_out,
    input wire logic        frame_clock_out,
    input wire logic        core_clock_out,
    input wire logic        sink_room_ready,
    input wire logic        acq_start_strobe,
    input wire logic        acquisition_marker,
    input wire logic [25:0] mission_time_counter,
    input wire logic        tm_serial_clock,
    input wire logic        tm_serial_valid
);
    // ========
    // Helpers
    localparam int MK_LO = MARK_TICKS - 2;   // Pin-to-core skew allowance
    localparam int MK_HI = MARK_TICKS + 2;
    logic       m_q_r;      // Master pin one clk late
    logic [19:0] mk_cnt_r;  // Master rises while marker high

    // Count master rises under the marker at the pin itself
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            m_q_r    <= 1'b0;
            mk_cnt_r <= 20'h00000;
        end
        else
        begin
            m_q_r <= master_clock_in;
            if (!acquisition_marker)
                mk_cnt_r <= 20'h00000;
            else if (master_clock_in && !m_q_r)
                mk_cnt_r <= mk_cnt_r + 20'h00001;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // ========
    // Assertions
    a_conv_div:
        assert property ($changed(conv_encoder_clock_out) |-> $fell(core_clock_out))
        else $error("conv clock moved off a core clock fall");
    a_frame_div:
        assert property ($changed(frame_clock_out) |-> $fell(conv_encoder_clock_out))
        else $error("frame clock moved off a conv clock fall");
    a_core_half:
        assert property ($rose(core_clock_out) |-> core_clock_out [*4])
        else $error("core clock high phase too short");
    a_serial_clk:
        assert property ($changed(tm_serial_valid) |-> $fell(tm_serial_clock))
        else $error("serial valid moved off a serial clock fall");
    a_valid_edge:
        assert property ($changed(tm_serial_valid) |-> !tm_serial_clock)
        else $error("serial valid changed while serial clock high");
    a_slot_time:
        assert property (acq_start_strobe |-> ##[0:1] (mission_time_counter[3:0] == 4'h0))
        else $error("acquisition started off a four second slot");
    a_ready_gate:
        assert property (!sink_room_ready [*4] |=> !acq_start_strobe)
        else $error("acquisition started without room");
    a_marker_go:
        assert property (acq_start_strobe |=> acquisition_marker)
        else $error("marker missing after acquisition start");
    a_marker_cause:
        assert property ($rose(acquisition_marker) |-> $past(acq_start_strobe))
        else $error("marker rose without acquisition start");
    a_marker_len:
        assert property ($fell(acquisition_marker) |-> mk_cnt_r >= MK_LO && mk_cnt_r <= MK_HI)
        else $error("marker width wrong");
    a_time_step:
        assert property ($changed(mission_time_counter)
                         |-> mission_time_counter == $past(mission_time_counter) + 26'h1)
        else $error("mission time did not step by one");
endmodule // hpa_checker

bind hpa_top hpa_checker #(.MARK_TICKS(MARK_TICKS)) i_chk (
    .clk(clk), .rstn(rstn), .master_clock_in(master_clock_in),
    .conv_encoder_clock_out(conv_encoder_clock_out), .frame_clock_out(frame_clock_out),
    .core_clock_out(core_clock_out), .sink_room_ready(sink_room_ready),
    .acq_start_strobe(acq_start_strobe), .acquisition_marker(acquisition_marker),
    .mission_time_counter(mission_time_counter), .tm_serial_clock(tm_serial_clock),
    .tm_serial_valid(tm_serial_valid)
);

`default_nettype wire

// ### dv/tb.sv
// Self-checking testbench for the housekeeping packet assembler
`timescale 1ns/1ps
`default_nettype none

module tb;
    // ========
    // Signals
    logic        clk;
    logic        rstn;
    logic        master_clock_in = 1'b0;
    logic [1:0]  mdiv = 2'h0;           // Master is clk / 4 to keep the run short
    logic        room_en;
    logic [15:0] discrete_inputs;
    wire  [7:0]  aux_octet_data;
    wire  [6:0]  aux_idx;
    wire  [25:0] met;
    wire         conv, frame, core, ready, acq, sun, marker, tclk, tvalid, tdata;
    wire  [2:0]  clk_outs;
    int          num_errors = 0;
    int          comparisons = 0;
    int          cycles = 0;

    assign clk_outs = {frame, conv, core};
    // Sub-module stand-in answers each offered index at once
    assign aux_octet_data = {1'b0, aux_idx} ^ 8'h5a;

    hpa_top #(.QSEC_TICKS(4), .MARK_TICKS(32)) i_dut (
        .clk(clk), .rstn(rstn), .master_clock_in(master_clock_in),
        .conv_encoder_clock_out(conv), .frame_clock_out(frame), .core_clock_out(core),
        .sink_room_ready(ready), .discrete_inputs(discrete_inputs),
        .aux_octet_index(aux_idx), .aux_octet_data(aux_octet_data),
        .acq_start_strobe(acq), .sun_sample_strobe(sun), .acquisition_marker(marker),
        .mission_time_counter(met), .tm_serial_clock(tclk),
        .tm_serial_valid(tvalid), .tm_serial_data(tdata));

    hpa_sink_model i_sink (
        .room_en(room_en), .sink_room_ready(ready), .tm_serial_clock(tclk),
        .tm_serial_valid(tvalid), .tm_serial_data(tdata));

    // Clock, master pin and hang guard
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
    begin
        mdiv            <= mdiv + 2'h1;
        master_clock_in <= mdiv[1];
        cycles          <= cycles + 1;
        if (cycles == 90000)
        begin
            num_errors++;
            print_verdict();
        end
    end

    // ========
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
            rev8[i] = v[7 - i];
    endfunction

    // ========
    // Scenarios
    // No room over the slot at 4 s: nothing may start
    task automatic t_skip_slot();
        int n = 0;
        int hits = 0;
        while (met[25:2] !== 24'd5 && n < 4000)
        begin
            @(negedge clk);
            n++;
            hits += (acq !== 1'b0 || marker !== 1'b0);
        end
        check(hits, 0);
        @(posedge clk);
        room_en <= 1'b1;
    endtask

    // Deferred acquisition at 8 s, marker width in master edges
    task automatic t_acq_start();
        int n = 0;
        while (acq !== 1'b1 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        check(marker, 1'b1);
        check(met[25:2], 24'd8);
        n = 0;
        while (marker === 1'b1 && n < 1000)
        begin
            @(negedge clk);
            n++;
        end
        check((n + 3) / 4, 32);
    endtask

    // Output clock periods in clk cycles: master is 4 clk
    task automatic t_clock_div();
        int   exp_p[3] = '{64, 256, 512};
        time  t0;
        for (int s = 0; s < 3; s++)
        begin
            @(posedge clk_outs[s]);
            t0 = $time;
            @(posedge clk_outs[s]);
            check(32'(($time - t0) / 20), exp_p[s]);
        end
    endtask

    // First packet carries the 8 s acquisition
    task automatic t_packet_head();
        logic [23:0] c = 24'd8;
        logic [7:0]  exp_o[16];
        int          n = 0;
        exp_o = '{8'h87, 8'h77, {2'b11, c[15:10]}, c[9:2], 8'h00, 8'h3e,
                  8'heb, 8'h90, 8'hc0, 8'h24, c[23:16], c[15:8], c[7:0],
                  rev8(discrete_inputs[7:0]), rev8(discrete_inputs[15:8]), 8'h55};
        while (i_sink.octets.size() < 16 && n < 80000)
        begin
            @(negedge clk);
            n++;
        end
        check(i_sink.octets.size() >= 16, 1'b1);
        for (int k = 0; k < 16 && k < i_sink.octets.size(); k++)
            check(i_sink.octets[k], exp_o[k]);
    endtask

    // ========
    // Main sequence
    initial
    begin
        rstn            = 1'b0;
        room_en         = 1'b0;
        discrete_inputs = 16'h1234;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        check(met, 0);
        t_skip_slot();
        t_acq_start();
        t_clock_div();
        t_packet_head();
        print_verdict();
    end
endmodule // tb

`default_nettype wire
